// >>> hdl/acms_pkg.sv
/*
  Shared constants and carriers of the axis control mode switcher.
  Assumes a 32-bit APB with byte addresses and a 40 MHz pclk.
*/
package acms_pkg;
  localparam int NAX = 4;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] GCTRL_OFS = 12'h000;
  localparam logic [11:0] GSTAT_OFS = 12'h004;
  localparam logic [11:0] SWERR_OFS = 12'h008;
  localparam logic [11:0] RANGE_OFS = 12'h00C;
  localparam logic [6:0] AX_BASE_IDX = 7'h01;
  localparam logic [2:0] A_CFG = 3'h0;
  localparam logic [2:0] A_CMD = 3'h1;
  localparam logic [2:0] A_TLDEV = 3'h2;
  localparam logic [2:0] A_TLIND = 3'h3;
  localparam logic [2:0] A_STAT = 3'h4;
  localparam logic [2:0] A_MINOR = 3'h5;
  localparam logic [2:0] A_MAJOR = 3'h6;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int G_TO_REAL = 0;
  localparam int G_TO_VIRT = 1;
  localparam int G_SON = 2;
  localparam int G_READY = 3;
  localparam int C_CAM = 0;
  localparam int C_CLUTCH = 1;
  localparam int C_CL_ON = 2;
  localparam int C_CONT_OK = 3;
  localparam int C_TLDEV = 4;
  localparam int K_REQ = 2;
  localparam int K_STOP = 3;
  localparam int K_SOFF = 4;
  localparam int K_TLGEN = 5;
  localparam int P_RUN = 0;
  localparam int P_EXTSTOP = 1;
  localparam int P_FLS = 2;
  localparam int P_RLS = 3;
  localparam int P_SWLIM = 4;
  localparam int P_ESTOP = 5;
  localparam int P_PWROFF = 6;
  localparam int P_SVERR = 7;
  // ----------------------------------------------------------------
  // Reset values and error codes
  // ----------------------------------------------------------------
  localparam logic [15:0] RANGE_RST = 16'h012C;
  localparam logic [15:0] TL_RST = 16'h012C;
  localparam logic [15:0] E_CAM = 16'h1860;
  localparam logic [15:0] E_RUNNING = 16'h1838;
  localparam logic [15:0] E_TLRANGE = 16'h186A;
  localparam logic [15:0] E_NOCONT = 16'h2B2A;
  localparam logic [15:0] E_NOTPOS = 16'h0100;
  localparam logic [15:0] E_XSTART = 16'h272E;
  localparam logic [15:0] E_XSTOP = 16'h2B0C;
  localparam logic [15:0] E_SOFF = 16'h1770;
  localparam logic [15:0] E_SWLIM = 16'h178E;
  localparam logic [15:0] E_FLS = 16'h2B16;
  localparam logic [15:0] E_RLS = 16'h2B20;
  localparam logic [15:0] E_AMP = 16'h2B02;
  localparam logic [15:0] E_READY = 16'hF002;
  localparam logic [15:0] E_FSTOP = 16'hF000;
  localparam logic [15:0] E_SVERR = 16'hF001;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    M_POS = 2'b00,
    M_SPD = 2'b01,
    M_TRQ = 2'b10,
    M_CNT = 2'b11
  } acms_mode_type;
  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] p;
    acms_mode_type mode;
    logic err;
    logic [15:0] minor;
    logic [15:0] major;
    logic [15:0] tlp;
    logic [15:0] tln;
    logic [4:0] cfg;
    logic stopc;
    logic soffc;
    logic clutch_off;
    logic son;
    logic halt;
  } acms_axis_type;
  typedef struct packed {
    acms_mode_type mode;
    logic servo_on;
    logic halt;
    logic clutch_off;
    logic spd_from_cmd;
    logic accdec_valid;
    logic [15:0] tl_pos;
    logic [15:0] tl_neg;
  } acms_amp_out_type;
endpackage : acms_pkg

// >>> hdl/acms_switcher.sv
/*
  Per-axis control mode supervisor with an APB register file.
  Assumes pin inputs asynchronous to pclk; APB master on pclk.
*/
// Local design decisions: the register offsets and register access over APB.
// Contract
// - Mode change request on a cam axis is refused with minor 6240.
// - Speed or torque entry only while motor stopped, else minor 6200.
// - Continuous-to-torque entry is accepted even while motor runs; the code refuses it with minor 6200 while the motor runs.
// - Speed-torque uses command speed; accel, decel, initial speed invalid.
// - General torque limit change request has no effect in speed-torque.
// - Setting-device torque limit applies within range, else minor 6250.
// - Individual torque change only without setting device; overrange gives 6250.
// - Continuous mode on unsupported amplifier gives major 11050, clutch off.
// - Virtual-to-real refused with error 256 unless all axes in position.
// - Stop command ignored during speed-torque control in virtual mode.
// - External stop: 10030 at virtual start, 11020 during motion.
// - All-axes servo-on release ignored in virtual, applied on return to real.
// - Servo-off gives 6000 if clutch engaged, else deferred until position.
// - Software stroke limit in speed-torque control gives minor 6030.
// - Hardware stroke limit gives major 11030 or 11040.
// - Forced stop: error F000, real mode, position control at servo-off.
// - Amplifier forced stop: 11010 if clutch engaged, else position at servo-off.
// - Servo error: error F001, real mode, position control at servo-off.
// - Amplifier power loss: 11010 if engaged, else position on power return.
// - Real-mode axes may switch to real mode during speed-torque control.
// - Each axis error sets the axis error flag and stores the code by class; system errors go to swerr only.
`timescale 1ns/100ps
module acms_switcher
  import acms_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic forced_stop_in,
  input wire logic [NAX-1:0][7:0] axis_pin_in,
  // Amplifier side
  output acms_amp_out_type [NAX-1:0] amp_out
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    acms_axis_type [NAX-1:0] ax;
    logic virt;
    logic son_eff;
    logic son_cmd;
    logic ready;
    logic ready_p;
    logic halt_all;
    logic [15:0] swerr;
    logic [15:0] range;
    logic fs1;
    logic fs2;
    logic fsp;
    logic [31:0] rdata;
    logic bad;
  } acms_state_type;

  acms_state_type q, d;

  function automatic logic spdtrq(input acms_mode_type m);
    spdtrq = (m != M_POS);
  endfunction : spdtrq

  function automatic logic engaged(input acms_axis_type a);
    engaged = ~a.cfg[C_CLUTCH] | (a.cfg[C_CL_ON] & ~a.clutch_off);
  endfunction : engaged

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic wr;
    logic rd;
    logic any_nonpos;
    logic any_xstop;
    logic sverr;
    logic [2:0] wo;
    logic hit;
    logic [15:0] v;
    logic [15:0] vn;
    logic [7:0] rise;
    logic [7:0] fall;
    d = q;
    wr = psel & penable & pwrite;
    rd = psel & ~penable & ~pwrite;
    wo = paddr[4:2];
    any_nonpos = 1'b0;
    any_xstop = 1'b0;
    sverr = 1'b0;
    hit = 1'b0;
    v = pwdata[15:0];
    vn = pwdata[31:16];
    rise = 8'h00;
    fall = 8'h00;
    d.fs1 = forced_stop_in;
    d.fs2 = q.fs1;
    d.fsp = q.fs2;
    d.ready_p = q.ready;
    for (int i = 0; i < NAX; i++) begin
      any_nonpos = any_nonpos | spdtrq(q.ax[i].mode);
      any_xstop = any_xstop | q.ax[i].s2[P_EXTSTOP];
      sverr = sverr | (q.ax[i].s2[P_SVERR] & ~q.ax[i].p[P_SVERR]);
    end
    // ----------------------------------------------------------------
    // Global registers
    // ----------------------------------------------------------------
    if (q.virt) begin
      d.son_eff = q.son_eff | q.son_cmd;
    end else begin
      d.son_eff = q.son_cmd;
    end
    if (wr && paddr == GCTRL_OFS) begin
      d.son_cmd = pwdata[G_SON];
      d.ready = pwdata[G_READY];
      if (pwdata[G_READY]) begin
        d.halt_all = 1'b0;
      end
      if (pwdata[G_TO_REAL] && q.virt) begin
        if (any_nonpos) begin
          d.swerr = E_NOTPOS;
        end else begin
          d.virt = 1'b0;
          d.son_eff = q.son_cmd;
        end
      end
      if (pwdata[G_TO_VIRT] && !q.virt && q.ready) begin
        if (any_xstop) begin
          for (int i = 0; i < NAX; i++) begin
            if (q.ax[i].s2[P_EXTSTOP]) begin
              d.ax[i].major = E_XSTART;
              d.ax[i].err = 1'b1;
            end
          end
        end else begin
          d.virt = 1'b1;
        end
      end
    end
    if (wr && paddr == SWERR_OFS) begin
      d.swerr = 16'h0000;
    end
    if (wr && paddr == RANGE_OFS) begin
      d.range = v;
    end
    if (q.virt && q.ready_p && !q.ready) begin
      d.swerr = E_READY;
      d.virt = 1'b0;
      d.halt_all = 1'b1;
      d.son_eff = q.son_cmd;
    end
    if (q.virt && q.fs2 && !q.fsp) begin
      d.swerr = E_FSTOP;
      d.virt = 1'b0;
      d.son_eff = q.son_cmd;
    end
    if (q.virt && sverr) begin
      d.swerr = E_SVERR;
      d.virt = 1'b0;
      d.son_eff = q.son_cmd;
    end
    // ----------------------------------------------------------------
    // Axes
    // ----------------------------------------------------------------
    for (int i = 0; i < NAX; i++) begin
      d.ax[i].s1 = axis_pin_in[i];
      d.ax[i].s2 = q.ax[i].s1;
      d.ax[i].p = q.ax[i].s2;
      rise = q.ax[i].s2 & ~q.ax[i].p;
      fall = ~q.ax[i].s2 & q.ax[i].p;
      if (wr && paddr[11:5] == AX_BASE_IDX + 7'(i)) begin
        hit = 1'b1;
        case (wo)
          A_CFG: begin
            d.ax[i].cfg = pwdata[4:0];
          end
          A_CMD: begin
            d.ax[i].stopc = pwdata[K_STOP];
            d.ax[i].soffc = pwdata[K_SOFF];
            if (pwdata[K_SOFF] && !q.ax[i].soffc && q.virt && engaged(q.ax[i])) begin
              d.ax[i].minor = E_SOFF;
              d.ax[i].err = 1'b1;
            end
            if (pwdata[K_TLGEN] && !spdtrq(q.ax[i].mode)) begin
              d.ax[i].tlp = q.range;
              d.ax[i].tln = q.range;
            end
            if (pwdata[K_REQ]) begin
              if (q.ax[i].cfg[C_CAM]) begin
                d.ax[i].minor = E_CAM;
                d.ax[i].err = 1'b1;
              end else if (pwdata[1:0] == M_CNT) begin
                if (!q.ax[i].cfg[C_CONT_OK]) begin
                  d.ax[i].major = E_NOCONT;
                  d.ax[i].err = 1'b1;
                  d.ax[i].clutch_off = q.ax[i].cfg[C_CLUTCH];
                end else begin
                  d.ax[i].mode = M_CNT;
                end
              end else if (pwdata[1:0] != M_POS && q.ax[i].s2[P_RUN]) begin
                d.ax[i].minor = E_RUNNING;
                d.ax[i].err = 1'b1;
              end else begin
                d.ax[i].mode = acms_mode_type'(pwdata[1:0]);
              end
            end
          end
          A_TLDEV: begin
            if (q.ax[i].cfg[C_TLDEV]) begin
              if (v > q.range) begin
                d.ax[i].minor = E_TLRANGE;
                d.ax[i].err = 1'b1;
              end else begin
                d.ax[i].tlp = v;
                d.ax[i].tln = v;
              end
            end
          end
          A_TLIND: begin
            if (!q.ax[i].cfg[C_TLDEV]) begin
              if (v > q.range || vn > q.range) begin
                d.ax[i].minor = E_TLRANGE;
                d.ax[i].err = 1'b1;
              end else begin
                d.ax[i].tlp = v;
                d.ax[i].tln = vn;
              end
            end
          end
          A_STAT: begin
            d.ax[i].err = 1'b0;
            d.ax[i].clutch_off = 1'b0;
          end
          default: begin
            hit = 1'b1;
          end
        endcase
      end
      // Pin events are applied after software clears, so a set wins.
      if (q.virt && spdtrq(q.ax[i].mode)) begin
        if (rise[P_EXTSTOP]) begin
          d.ax[i].major = E_XSTOP;
          d.ax[i].err = 1'b1;
          d.ax[i].clutch_off = q.ax[i].cfg[C_CLUTCH];
        end
        if (rise[P_SWLIM]) begin
          d.ax[i].minor = E_SWLIM;
          d.ax[i].err = 1'b1;
        end
        if (rise[P_FLS] || rise[P_RLS]) begin
          d.ax[i].major = rise[P_FLS] ? E_FLS : E_RLS;
          d.ax[i].err = 1'b1;
          d.ax[i].clutch_off = q.ax[i].cfg[C_CLUTCH];
        end
        if ((rise[P_ESTOP] || rise[P_PWROFF]) && engaged(q.ax[i])) begin
          d.ax[i].major = E_AMP;
          d.ax[i].err = 1'b1;
          d.ax[i].clutch_off = q.ax[i].cfg[C_CLUTCH];
        end
      end
      if (fall[P_PWROFF] && !engaged(q.ax[i])) begin
        d.ax[i].mode = M_POS;
      end
      // Servo-off in real mode, or with a free clutch, returns to position.
      if (!q.ax[i].son && !q.ax[i].s2[P_PWROFF] && (!q.virt || !engaged(q.ax[i]))) begin
        d.ax[i].mode = M_POS;
      end
      if (q.virt && q.ready_p && !q.ready) begin
        d.ax[i].mode = M_POS;
      end
      d.ax[i].son = q.son_eff & ~q.fs2 & ~q.ax[i].s2[P_ESTOP] & ~q.ax[i].s2[P_PWROFF]
                    & ~(q.ax[i].soffc & (~q.virt | (~engaged(q.ax[i])
                    & ~spdtrq(q.ax[i].mode))));
      d.ax[i].halt = q.halt_all | (q.ax[i].stopc & (~q.virt | ~spdtrq(q.ax[i].mode)));
    end
    if (wr && !hit && paddr != GCTRL_OFS && paddr != SWERR_OFS && paddr != RANGE_OFS) begin
      d.bad = 1'b1;
    end else begin
      d.bad = 1'b0;
    end
    // ----------------------------------------------------------------
    // Read data, captured in the setup cycle
    // ----------------------------------------------------------------
    if (psel && !penable) begin
      d.rdata = 32'h0000_0000;
      d.bad = 1'b0;
      if (paddr == GCTRL_OFS) begin
        d.rdata = {28'h0, q.ready, q.son_cmd, 2'b00};
      end else if (paddr == GSTAT_OFS) begin
        d.rdata = {29'h0, q.halt_all, q.son_eff, q.virt};
      end else if (paddr == SWERR_OFS) begin
        d.rdata = {16'h0, q.swerr};
      end else if (paddr == RANGE_OFS) begin
        d.rdata = {16'h0, q.range};
      end else begin
        d.bad = 1'b1;
        for (int i = 0; i < NAX; i++) begin
          if (paddr[11:5] == AX_BASE_IDX + 7'(i) && paddr[1:0] == 2'b00) begin
            d.bad = (wo == 3'h7) | (pwrite & (wo == A_MINOR || wo == A_MAJOR));
            case (wo)
              A_CFG: d.rdata = {27'h0, q.ax[i].cfg};
              A_CMD: d.rdata = {27'h0, q.ax[i].soffc, q.ax[i].stopc, 1'b0, q.ax[i].mode};
              A_TLDEV: d.rdata = 32'h0;
              A_TLIND: d.rdata = {q.ax[i].tln, q.ax[i].tlp};
              A_STAT: d.rdata = {27'h0, q.ax[i].clutch_off, q.ax[i].son, q.ax[i].err,
                                 q.ax[i].mode};
              A_MINOR: d.rdata = {16'h0, q.ax[i].minor};
              A_MAJOR: d.rdata = {16'h0, q.ax[i].major};
              default: d.rdata = 32'h0;
            endcase
          end
        end
      end
      if (!rd) begin
        d.rdata = q.rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      for (int i = 0; i < NAX; i++) begin
        q.ax[i].tlp <= TL_RST;
        q.ax[i].tln <= TL_RST;
      end
      q.range <= RANGE_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // The slave never stretches a transfer; errors show only on pslverr.
  assign pready = 1'b1;
  assign pslverr = psel & penable & q.bad;
  assign prdata = q.rdata;

  for (genvar g = 0; g < NAX; g++) begin : g_amp
    assign amp_out[g].mode = q.ax[g].mode;
    assign amp_out[g].servo_on = q.ax[g].son;
    assign amp_out[g].halt = q.ax[g].halt;
    assign amp_out[g].clutch_off = q.ax[g].clutch_off;
    assign amp_out[g].spd_from_cmd = spdtrq(q.ax[g].mode);
    assign amp_out[g].accdec_valid = ~spdtrq(q.ax[g].mode);
    assign amp_out[g].tl_pos = q.ax[g].tlp;
    assign amp_out[g].tl_neg = q.ax[g].tln;
  end
endmodule : acms_switcher

// >>> verification/acms_switcher_props.sv
/*
  Concurrent checks on the ports of the axis control mode switcher.
  Assumes the register offsets and field positions of acms_pkg.
*/
`timescale 1ns/100ps
module acms_switcher_props
  import acms_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and amplifiers
  input wire logic forced_stop_in,
  input wire logic [NAX-1:0][7:0] axis_pin_in,
  input acms_amp_out_type [NAX-1:0] amp_out
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr, w0, rdy_q, all_pos, dec_ok;
  logic [15:0] rng_q;
  logic [2:0] quiet_q;
  logic [NAX*8:0] pin_q;
  assign wr = psel && penable && pwrite;
  assign w0 = wr && paddr[11:5] == AX_BASE_IDX && paddr[1:0] == 2'h0;
  always_comb begin
    all_pos = 1'h1;
    dec_ok = 1'h1;
    for (int i = 0; i < NAX; i++) begin
      all_pos = all_pos && amp_out[i].mode == M_POS;
      dec_ok = dec_ok && amp_out[i].spd_from_cmd == (amp_out[i].mode != M_POS)
        && amp_out[i].accdec_valid == (amp_out[i].mode == M_POS);
    end
  end
  // Pins pass a synchroniser, so quiet counts from the last input change or APB write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_q <= 1'h0;
      rng_q <= RANGE_RST;
      quiet_q <= 3'h0;
      pin_q <= '0;
    end else begin
      pin_q <= {forced_stop_in, axis_pin_in};
      if (wr && paddr == GCTRL_OFS) rdy_q <= pwdata[G_READY];
      if (wr && paddr == RANGE_OFS) rng_q <= pwdata[15:0];
      if (wr || pin_q != {forced_stop_in, axis_pin_in}) quiet_q <= 3'h0;
      else if (quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_speed_decode: assert property (dec_ok)
    else $error("speed source decode wrong");
  a_general_tl_off: assert property (w0 && paddr[4:2] == A_CMD && pwdata[K_TLGEN]
    && amp_out[0].mode != M_POS |=> $stable(amp_out[0].tl_pos) && $stable(amp_out[0].tl_neg))
    else $error("general torque change acted");
  a_device_tl_range: assert property (w0 && paddr[4:2] == A_TLDEV && pwdata[15:0] > rng_q
    |=> $stable(amp_out[0].tl_pos) && $stable(amp_out[0].tl_neg))
    else $error("overrange device limit applied");
  a_indiv_tl_range: assert property (w0 && paddr[4:2] == A_TLIND
    && (pwdata[15:0] > rng_q || pwdata[31:16] > rng_q)
    |=> $stable(amp_out[0].tl_pos) && $stable(amp_out[0].tl_neg))
    else $error("overrange individual limit applied");
  a_real_refused: assert property (wr && paddr == GCTRL_OFS && pwdata[G_TO_REAL]
    && pwdata[G_READY] && !all_pos |=> !all_pos)
    else $error("modes changed by refused switch");
  a_stop_ignored: assert property (w0 && paddr[4:2] == A_CMD && pwdata[K_STOP]
    && amp_out[0].mode != M_POS |=> (!$rose(amp_out[0].halt))[*2])
    else $error("stop command halted axis");
  a_ready_drop: assert property (wr && paddr == GCTRL_OFS && !pwdata[G_READY] && rdy_q
    |-> ##[1:2] all_pos)
    else $error("ready drop kept a mode");
  a_quiet_hold: assert property (quiet_q >= 3'h5 |-> $stable(amp_out))
    else $error("amplifier outputs moved unprompted");
  c_tl_refused: cover property (w0 && paddr[4:2] == A_TLIND && pwdata[15:0] > rng_q);
  c_torque_mode: cover property (amp_out[0].mode == M_TRQ);
  c_ready_drop: cover property (wr && paddr == GCTRL_OFS && !pwdata[G_READY] && rdy_q);
endmodule : acms_switcher_props

bind acms_switcher acms_switcher_props acms_switcher_props_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .forced_stop_in(forced_stop_in),
  .axis_pin_in(axis_pin_in), .amp_out(amp_out));

// >>> verification/acms_amp_model.sv
/*
  Far side model: servo amplifiers, motors and the controller stop input.
  Assumes the bench asks for motion and faults on pclk edges.
*/
`timescale 1ns/100ps
module acms_amp_model
  import acms_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // From the switcher
  input acms_amp_out_type [NAX-1:0] amp_out,
  // Bench requests
  input wire logic [NAX-1:0] run_req,
  input wire logic [NAX-1:0][6:0] flt_req,
  input wire logic stop_req,
  // Pins
  output logic [NAX-1:0][7:0] pins,
  output logic forced_stop
);
  // A motor turns only while its amplifier is on and not halted.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins <= '0;
      forced_stop <= 1'h0;
    end else begin
      forced_stop <= stop_req;
      for (int i = 0; i < NAX; i++) begin
        pins[i] <= {flt_req[i], run_req[i] && amp_out[i].servo_on && !amp_out[i].halt};
      end
    end
  end
endmodule : acms_amp_model

// >>> verification/acms_switcher_tb.sv
/*
  Self-checking bench of the axis control mode switcher.
  Assumes acms_amp_model on the far side and the bound checker.
*/
`timescale 1ns/100ps
module acms_switcher_tb
  import acms_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fstop, stop_req, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] rng, tp, tn, p, n;
  logic [NAX-1:0] run_req;
  logic [NAX-1:0][6:0] flt_req;
  logic [NAX-1:0][7:0] pins;
  acms_amp_out_type [NAX-1:0] amp_out;
  int n_fail, tests_run, cyc_n;
  localparam logic [15:0] PCODE [6] = '{E_XSTOP, E_FLS, E_RLS, E_SWLIM, E_AMP, E_AMP};
  acms_switcher acms_switcher_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .forced_stop_in(fstop), .axis_pin_in(pins),
    .amp_out(amp_out));
  acms_amp_model acms_amp_model_i (.pclk(pclk), .presetn(presetn), .amp_out(amp_out),
    .run_req(run_req), .flt_req(flt_req), .stop_req(stop_req), .pins(pins),
    .forced_stop(fstop));
  // ----------------------------------------------------------------
  // Clock, timeout and tasks
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'h0;
    forever #12.5 pclk = ~pclk;
  end
  // A hang is cut short well above the expected run of some 370 cycles.
  always @(posedge pclk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000) begin
      n_fail++;
      complete_run();
    end
  end
  task complete_run;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  task xfer(input logic wd, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= wd;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : xfer
  task w(input logic [11:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask : w
  task ck(input string nm, input logic [15:0] ex, input logic [15:0] got);
    tests_run++;
    if (got !== ex) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask : ck
  task rc(input string nm, input logic [11:0] a, input logic [15:0] ex,
    input logic [15:0] m = 16'hFFFF);
    xfer(1'h0, a, 32'h0);
    ck(nm, ex & m, r[15:0] & m);
  endtask : rc
  function automatic logic [11:0] ax(input int i, input logic [2:0] o);
    return 12'((i + 1) * 32) | {7'h00, o, 2'h0};
  endfunction : ax
  function automatic logic fits(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    return a <= c && b <= c;
  endfunction : fits
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, stop_req} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    run_req = '0;
    flt_req = '0;
    {n_fail, tests_run, cyc_n} = '0;
    void'($urandom(32'h7e3a));
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rc("range reset", RANGE_OFS, RANGE_RST);
    xfer(1'h0, 12'h010, 32'h0);
    ck("unmapped", 16'h1, 16'(e));
    w(ax(0, A_MINOR), 32'h1);
    ck("code write", 16'h1, 16'(e));
    flt_req[3][0] <= 1'h1;
    repeat (5) @(posedge pclk);
    w(GCTRL_OFS, 32'hC);
    w(GCTRL_OFS, 32'hE);
    rc("start refused", GSTAT_OFS, 16'h0, 16'h1);
    rc("start code", ax(3, A_MAJOR), E_XSTART);
    flt_req[3][0] <= 1'h0;
    repeat (5) @(posedge pclk);
    w(GCTRL_OFS, 32'hE);
    rc("virtual", GSTAT_OFS, 16'h3, 16'h3);
    $display("test entry done");
    w(ax(1, A_CFG), 32'h1);
    w(ax(1, A_CMD), 32'h5);
    rc("cam mode", ax(1, A_STAT), 16'h0, 16'h3);
    rc("cam code", ax(1, A_MINOR), E_CAM);
    run_req[0] <= 1'h1;
    repeat (6) @(posedge pclk);
    w(ax(0, A_CMD), 32'h5);
    rc("run code", ax(0, A_MINOR), E_RUNNING);
    rc("run mode", ax(0, A_STAT), 16'h0, 16'h3);
    w(ax(0, A_CFG), 32'h8);
    w(ax(0, A_CMD), 32'h7);
    rc("cont mode", ax(0, A_STAT), 16'h3, 16'h3);
    run_req[0] <= 1'h0;
    repeat (6) @(posedge pclk);
    w(ax(0, A_CMD), 32'h6);
    rc("torque mode", ax(0, A_STAT), 16'h2, 16'h3);
    w(ax(2, A_CFG), 32'h6);
    w(ax(2, A_CMD), 32'h7);
    rc("cont code", ax(2, A_MAJOR), E_NOCONT);
    rc("clutch off", ax(2, A_STAT), 16'h10, 16'h13);
    $display("test modes done");
    rng = 16'h00C8;
    w(RANGE_OFS, 32'(rng));
    w(ax(0, A_CMD), 32'h20);
    ck("general tl", TL_RST, amp_out[0].tl_pos);
    tp = TL_RST;
    tn = TL_RST;
    for (int i = 0; i < 8; i++) begin
      p = (i < 2) ? rng + 16'(i) : 16'($urandom_range(400));
      n = (i < 2) ? rng : 16'($urandom_range(400));
      w(ax(0, A_TLIND), {n, p});
      if (fits(p, n, rng)) begin
        tp = p;
        tn = n;
      end
      ck("tl pos", tp, amp_out[0].tl_pos);
      ck("tl neg", tn, amp_out[0].tl_neg);
    end
    rc("tl code", ax(0, A_MINOR), E_TLRANGE);
    w(ax(0, A_CFG), 32'h18);
    w(ax(0, A_TLDEV), 32'h64);
    ck("device tl", 16'h0064, amp_out[0].tl_pos);
    w(ax(0, A_TLDEV), 32'h100);
    ck("device over", 16'h0064, amp_out[0].tl_pos);
    w(ax(0, A_TLIND), 32'h00100010);
    ck("indiv blocked", 16'h0064, amp_out[0].tl_pos);
    $display("test torque done");
    w(ax(0, A_CMD), 32'h8);
    w(GCTRL_OFS, 32'hD);
    rc("real refused", SWERR_OFS, E_NOTPOS);
    rc("still virtual", GSTAT_OFS, 16'h1, 16'h1);
    ck("stop halt", 16'h0, 16'(amp_out[0].halt));
    ck("stop mode", 16'(M_TRQ), 16'(amp_out[0].mode));
    w(ax(0, A_CMD), 32'h10);
    rc("servo off", ax(0, A_MINOR), E_SOFF);
    w(ax(0, A_CMD), 32'h0);
    for (int j = 0; j < 6; j++) begin
      w(ax(0, A_STAT), 32'h0);
      flt_req[0][j] <= 1'h1;
      repeat (6) @(posedge pclk);
      rc("pin code", ax(0, j == 3 ? A_MINOR : A_MAJOR), PCODE[j]);
      rc("err flag", ax(0, A_STAT), 16'h4, 16'h4);
      flt_req[0][j] <= 1'h0;
      repeat (6) @(posedge pclk);
    end
    $display("test stops done");
    w(GCTRL_OFS, 32'h8);
    rc("son kept", GSTAT_OFS, 16'h2, 16'h2);
    w(GCTRL_OFS, 32'h0);
    rc("ready code", SWERR_OFS, E_READY);
    rc("ready real", GSTAT_OFS, 16'h0, 16'h3);
    ck("ready son", 16'h0, 16'(amp_out[0].servo_on));
    ck("ready mode", 16'(M_POS), 16'(amp_out[0].mode));
    w(SWERR_OFS, 32'h0);
    w(GCTRL_OFS, 32'hC);
    w(GCTRL_OFS, 32'hE);
    flt_req[1][6] <= 1'h1;
    repeat (6) @(posedge pclk);
    rc("fault code", SWERR_OFS, E_SVERR);
    rc("fault real", GSTAT_OFS, 16'h0, 16'h1);
    flt_req[1][6] <= 1'h0;
    repeat (6) @(posedge pclk);
    w(SWERR_OFS, 32'h0);
    w(GCTRL_OFS, 32'hE);
    stop_req <= 1'h1;
    repeat (6) @(posedge pclk);
    rc("fstop code", SWERR_OFS, E_FSTOP);
    rc("fstop real", GSTAT_OFS, 16'h0, 16'h1);
    stop_req <= 1'h0;
    $display("test fallback done");
    complete_run();
  end
endmodule : acms_switcher_tb
